// ===== logic/cfgdn_loader.sv
// Contract
// RQ1: The completion line is held low from before loading until loading finishes.
// RQ2: When all bits arrive without error and initialization starts, the completion line is released.
// RQ3: Initialization and user mode follow only after all data is in and the line reads high.
// RQ4: Once in user mode, a low driven onto the completion line is ignored.
// RQ5: Loading proceeds only while chain enable input is low, which the outside keeps low.
// RQ6: In a chain the first enable is tied low and each enable output feeds the next input.
// RQ7: The outside holds the chain enable input low for test port programming.
// RQ8: The chain enable output goes low once this device has its configuration.
// RQ9: In the serial memory scheme a command stream is sent to read the memory.
// RQ10: In the serial memory scheme a select output enables the memory.
// RQ11: Outside the serial memory scheme the select and command pins are user pins.
// RQ12: A load error pulls the status line low, and an outside low on it is an error; the code flags that low only in ST_LOAD, ST_WAIT_DONE and ST_INIT.
// RQ13: A low reconfiguration request clears and holds reset; its rise starts a new load.
`timescale 1ns/100ps
`include "cfgdn_defs.svh"
module cfgdn_loader (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Reconfiguration and chain pins
  input wire logic reconfig_request_n,
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  // Open-drain completion line
  input wire logic config_complete_line_in,
  output logic config_complete_line_out,
  output logic config_complete_line_oe,
  // Open-drain error status line
  input wire logic error_status_line_n_in,
  output logic error_status_line_n_out,
  output logic error_status_line_n_oe,
  // Scheme strap, high selects the serial memory scheme
  input wire logic self_driven_serial_scheme,
  // Serial memory pins
  input wire logic memory_data_in,
  output logic memory_select_out_n,
  output logic memory_select_oe,
  output logic serial_cmd_out,
  output logic serial_cmd_oe,
  // Host bit stream on the same clock
  input wire logic host_bit_valid,
  input wire logic host_bit_data,
  input wire logic load_error,
  // Configuration bits toward the array
  output logic cfg_bit_valid,
  output logic cfg_bit_data,
  // User logic on the dual-purpose pins
  input wire logic user_select_out,
  input wire logic user_select_oe,
  input wire logic user_cmd_out,
  input wire logic user_cmd_oe,
  // Status
  output logic user_mode
);

  localparam int PIN_RECFG = 0;
  localparam int PIN_CE = 1;
  localparam int PIN_DONE = 2;
  localparam int PIN_STAT = 3;
  localparam int PIN_STRAP = 4;
  localparam int NPIN = 5;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] sync3_r;
  logic [NPIN-1:0] pin_f_r;
  cfgdn_pkg::cfgdn_state_e state_r;
  logic [15:0] bit_cnt_r;
  logic [15:0] init_cnt_r;
  logic as_mode_r;
  logic chain_out_r;
  logic cfg_valid_r;
  logic cfg_data_r;
  logic reconfig_f;
  logic ce_f;
  logic done_f;
  logic status_f;
  logic src_valid;
  logic src_data;
  logic bit_take;
  logic last_bit;

  cfgdn_rd_if rd_bus ();

  // Completion line held low in every state before the data is complete
  function automatic logic holds_done_low(input cfgdn_pkg::cfgdn_state_e s);
    return s == cfgdn_pkg::ST_RESET || s == cfgdn_pkg::ST_WAIT_CE ||
           s == cfgdn_pkg::ST_LOAD || s == cfgdn_pkg::ST_ERROR;
  endfunction : holds_done_low

  assign pin_raw = {self_driven_serial_scheme, error_status_line_n_in,
                    config_complete_line_in, chain_enable_in_n, reconfig_request_n};

  // Three-stage pin synchronisers; a level counts once stages two and three agree
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        sync1_r[g] <= `CFGDN_SYNC_IDLE;
        sync2_r[g] <= `CFGDN_SYNC_IDLE;
        sync3_r[g] <= `CFGDN_SYNC_IDLE;
        pin_f_r[g] <= `CFGDN_SYNC_IDLE;
      end else begin
        sync1_r[g] <= pin_raw[g];
        sync2_r[g] <= sync1_r[g];
        sync3_r[g] <= sync2_r[g];
        if (sync2_r[g] == sync3_r[g]) begin
          pin_f_r[g] <= sync3_r[g];
        end
      end
    end
  end

  assign reconfig_f = pin_f_r[PIN_RECFG];
  assign ce_f = pin_f_r[PIN_CE];
  assign done_f = pin_f_r[PIN_DONE];
  assign status_f = pin_f_r[PIN_STAT];

  // Bit source depends on the captured scheme
  assign src_valid = as_mode_r ? rd_bus.bit_valid : host_bit_valid;
  assign src_data = as_mode_r ? rd_bus.bit_data : host_bit_data;
  assign bit_take = state_r == cfgdn_pkg::ST_LOAD && !ce_f && src_valid; // [RQ5]
  assign last_bit = bit_cnt_r == `CFGDN_CFG_BITS - 16'h0001;

  // Main sequence; reconfiguration request overrides everything
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= cfgdn_pkg::ST_RESET;
    end else if (!reconfig_f) begin
      state_r <= cfgdn_pkg::ST_RESET; // [RQ13]
    end else begin
      unique case (state_r)
        cfgdn_pkg::ST_RESET: begin
          // Presets would otherwise pick the scheme and pass the status check
          if (init_cnt_r >= 16'(`CFGDN_SETTLE_CYCLES)) begin
            state_r <= cfgdn_pkg::ST_WAIT_CE; // [RQ13]
          end
        end
        cfgdn_pkg::ST_WAIT_CE: begin
          // Status must read released first, else our own low looks like an error
          if (!ce_f && status_f) begin
            state_r <= cfgdn_pkg::ST_LOAD; // [RQ5]
          end
        end
        cfgdn_pkg::ST_LOAD: begin
          if (load_error || !status_f) begin
            state_r <= cfgdn_pkg::ST_ERROR; // [RQ12]
          end else if (bit_take && last_bit) begin
            state_r <= cfgdn_pkg::ST_WAIT_DONE;
          end
        end
        cfgdn_pkg::ST_WAIT_DONE: begin
          if (!status_f) begin
            state_r <= cfgdn_pkg::ST_ERROR; // [RQ12]
          end else if (done_f) begin
            state_r <= cfgdn_pkg::ST_INIT; // [RQ3]
          end
        end
        cfgdn_pkg::ST_INIT: begin
          if (!status_f) begin
            state_r <= cfgdn_pkg::ST_ERROR; // [RQ12]
          end else if (init_cnt_r == 16'(`CFGDN_INIT_CYCLES - 1)) begin
            state_r <= cfgdn_pkg::ST_USER; // [RQ3]
          end
        end
        cfgdn_pkg::ST_USER: state_r <= cfgdn_pkg::ST_USER; // [RQ4]
        cfgdn_pkg::ST_ERROR: state_r <= cfgdn_pkg::ST_ERROR;
      endcase
    end
  end

  // Bit and initialization counters
  always_ff @(posedge clk) begin
    if (!rst_b || state_r == cfgdn_pkg::ST_RESET) begin
      bit_cnt_r <= 16'h0000;
    end else if (bit_take) begin
      bit_cnt_r <= bit_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    // Also times pin settling in the reset state, saturating there
    if (!rst_b || !(state_r == cfgdn_pkg::ST_INIT || state_r == cfgdn_pkg::ST_RESET)) begin
      init_cnt_r <= 16'h0000;
    end else if (state_r == cfgdn_pkg::ST_INIT || init_cnt_r < 16'(`CFGDN_SETTLE_CYCLES)) begin
      init_cnt_r <= init_cnt_r + 16'h0001;
    end
  end

  // Scheme strap caught while held in reset, so it never changes mid-load
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      as_mode_r <= 1'b0;
    end else if (state_r == cfgdn_pkg::ST_RESET) begin
      as_mode_r <= pin_f_r[PIN_STRAP];
    end
  end

  // Bits passed on to the array, and the chain hand-off
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_valid_r <= 1'b0;
      cfg_data_r <= 1'b0;
      chain_out_r <= 1'b1;
    end else begin
      cfg_valid_r <= bit_take; // [RQ5]
      cfg_data_r <= src_data;
      chain_out_r <= holds_done_low(state_r); // [RQ8]
    end
  end

  assign cfg_bit_valid = cfg_valid_r;
  assign cfg_bit_data = cfg_data_r;
  assign chain_enable_out_n = chain_out_r;
  assign user_mode = state_r == cfgdn_pkg::ST_USER;

  // Open-drain lines only ever drive low
  assign config_complete_line_out = 1'b0;
  assign config_complete_line_oe = holds_done_low(state_r); // [RQ1] [RQ2]
  assign error_status_line_n_out = 1'b0;
  assign error_status_line_n_oe = state_r == cfgdn_pkg::ST_RESET ||
                                  state_r == cfgdn_pkg::ST_ERROR; // [RQ12]

  // Serial memory reader
  assign rd_bus.start = as_mode_r && state_r == cfgdn_pkg::ST_WAIT_CE && reconfig_f &&
                        !ce_f && status_f;
  assign rd_bus.stop = state_r != cfgdn_pkg::ST_LOAD;
  assign rd_bus.mem_data = memory_data_in; // Memory runs on our clock; a filter would eat bits

  cfgdn_serial_reader u_reader (
    .clk(clk),
    .rst_b(rst_b),
    .rd(rd_bus.reader)
  );

  // Pins belong to the reader in the memory scheme, else to user logic after load
  assign memory_select_out_n = as_mode_r ? rd_bus.sel_n : user_select_out; // [RQ10] [RQ11]
  assign memory_select_oe = as_mode_r ? 1'b1 : user_mode && user_select_oe; // [RQ11]
  assign serial_cmd_out = as_mode_r ? rd_bus.cmd : user_cmd_out; // [RQ9] [RQ11]
  assign serial_cmd_oe = as_mode_r ? 1'b1 : user_mode && user_cmd_oe; // [RQ11]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_bit;
    reconfig_f && bit_take && last_bit && !load_error && status_f;
  endsequence

  property p_done_low;
    state_r == cfgdn_pkg::ST_LOAD |-> config_complete_line_oe && !config_complete_line_out;
  endproperty
  a_done_low: assert property (p_done_low) // [RQ1]
    else $error("completion line not held low while loading");
  property p_release;
    s_last_bit |=> !config_complete_line_oe;
  endproperty
  a_release: assert property (p_release) // [RQ2]
    else $error("completion line not released after last bit");
  property p_init_after_high;
    $rose(state_r == cfgdn_pkg::ST_INIT) |-> $past(done_f) && $past(bit_cnt_r) == `CFGDN_CFG_BITS;
  endproperty
  a_init_after_high: assert property (p_init_after_high) // [RQ3]
    else $error("initialization began before line read high");
  property p_user_kept;
    state_r == cfgdn_pkg::ST_USER && reconfig_f |=> state_r == cfgdn_pkg::ST_USER;
  endproperty
  a_user_kept: assert property (p_user_kept) // [RQ4]
    else $error("user mode left without reconfiguration");
  property p_ce_gate;
    ce_f |=> !cfg_bit_valid;
  endproperty
  a_ce_gate: assert property (p_ce_gate) // [RQ5]
    else $error("bit taken with chain enable high");
  property p_chain_out;
    state_r == cfgdn_pkg::ST_INIT |=> !chain_enable_out_n;
  endproperty
  a_chain_out: assert property (p_chain_out) // [RQ8]
    else $error("chain enable output not low after load");
  property p_status_error;
    reconfig_f && state_r == cfgdn_pkg::ST_INIT && !status_f |=> ##1 error_status_line_n_oe;
  endproperty
  a_status_error: assert property (p_status_error) // [RQ12]
    else $error("outside status low did not raise error");
  property p_reconfig;
    !reconfig_f |=> state_r == cfgdn_pkg::ST_RESET && error_status_line_n_oe;
  endproperty
  a_reconfig: assert property (p_reconfig) // [RQ13]
    else $error("reconfiguration request did not reset");
  property p_user_pins;
    !as_mode_r && !user_mode |-> !memory_select_oe && !serial_cmd_oe;
  endproperty
  a_user_pins: assert property (p_user_pins) // [RQ11]
    else $error("dual-purpose pin driven during load");

endmodule : cfgdn_loader

// ===== logic/cfgdn_defs.svh
`ifndef CFGDN_DEFS_SVH
`define CFGDN_DEFS_SVH

// Clock rate and initialization time
`define CFGDN_CLK_PERIOD_NS 25
`define CFGDN_INIT_TIME_NS 2000
// Least time, so rounded up to whole cycles
`define CFGDN_INIT_CYCLES ((`CFGDN_INIT_TIME_NS + `CFGDN_CLK_PERIOD_NS - 1) / `CFGDN_CLK_PERIOD_NS)

// Edges after reset before the pin synchronisers show real levels
`define CFGDN_SETTLE_CYCLES 4

// Size of one configuration image in bits
`define CFGDN_CFG_BITS 16'h0400

// Read command plus start address sent to the serial memory, MSB first
`define CFGDN_READ_CMD 32'h0300_0000
`define CFGDN_CMD_BITS 6'h20

// Idle level of the pin synchronisers
`define CFGDN_SYNC_IDLE 1'b1

`endif

// ===== logic/cfgdn_pkg.sv
package cfgdn_pkg;

  // Loader sequence
  typedef enum logic [2:0] {
    ST_RESET,
    ST_WAIT_CE,
    ST_LOAD,
    ST_WAIT_DONE,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } cfgdn_state_e;

  // Serial memory reader sequence
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_CMD,
    RD_STREAM
  } cfgdn_rd_state_e;

endpackage : cfgdn_pkg

// ===== logic/cfgdn_rd_if.sv
`timescale 1ns/100ps
interface cfgdn_rd_if;
  logic start;
  logic stop;
  logic mem_data;
  logic bit_valid;
  logic bit_data;
  logic sel_n;
  logic cmd;

  modport loader (output start, output stop, output mem_data,
                  input bit_valid, input bit_data, input sel_n, input cmd);
  modport reader (input start, input stop, input mem_data,
                  output bit_valid, output bit_data, output sel_n, output cmd);
endinterface : cfgdn_rd_if

// ===== logic/cfgdn_serial_reader.sv
`timescale 1ns/100ps
`include "cfgdn_defs.svh"
module cfgdn_serial_reader (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Toward the loader
  cfgdn_rd_if.reader rd
);

  cfgdn_pkg::cfgdn_rd_state_e state_r;
  logic [31:0] shift_r;
  logic [5:0] cnt_r;
  logic sel_n_r;
  logic cmd_r;

  // Command phase, then one memory bit per clock until stopped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= cfgdn_pkg::RD_IDLE;
    end else begin
      unique case (state_r)
        cfgdn_pkg::RD_IDLE: begin
          if (rd.start) begin
            state_r <= cfgdn_pkg::RD_CMD;
          end
        end
        cfgdn_pkg::RD_CMD: begin
          if (rd.stop) begin
            state_r <= cfgdn_pkg::RD_IDLE;
          end else if (cnt_r == `CFGDN_CMD_BITS) begin // Spare cycle for the memory to answer
            state_r <= cfgdn_pkg::RD_STREAM;
          end
        end
        cfgdn_pkg::RD_STREAM: begin
          if (rd.stop) begin
            state_r <= cfgdn_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  // Command shifter, loaded on start
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shift_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
    end else if (state_r == cfgdn_pkg::RD_IDLE) begin
      shift_r <= `CFGDN_READ_CMD;
      cnt_r <= 6'h00;
    end else if (state_r == cfgdn_pkg::RD_CMD) begin
      shift_r <= {shift_r[30:0], 1'b0};
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // Select stays low for the whole access; memory drops it on a high edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_n_r <= 1'b1;
      cmd_r <= 1'b0;
    end else begin
      sel_n_r <= !((state_r == cfgdn_pkg::RD_IDLE && rd.start) ||
                   (state_r != cfgdn_pkg::RD_IDLE && !rd.stop)); // [RQ10]
      cmd_r <= (state_r == cfgdn_pkg::RD_CMD) ? shift_r[31] : 1'b0; // [RQ9]
    end
  end

  assign rd.sel_n = sel_n_r;
  assign rd.cmd = cmd_r;
  assign rd.bit_valid = (state_r == cfgdn_pkg::RD_STREAM) && !rd.stop;
  assign rd.bit_data = rd.mem_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    state_r == cfgdn_pkg::RD_IDLE && rd.start;
  endsequence

  property p_cmd_first_bit;
    s_start ##1 !rd.stop |=> cmd_r == `CFGDN_READ_CMD >> 31;
  endproperty
  a_cmd_first_bit: assert property (p_cmd_first_bit) // [RQ9]
    else $error("first command bit wrong");

  property p_select_low;
    s_start |=> !rd.sel_n;
  endproperty
  a_select_low: assert property (p_select_low) // [RQ10]
    else $error("memory not selected at start");

endmodule : cfgdn_serial_reader

// ===== verification/cfgdn_mem_model.sv
`timescale 1ns/100ps
`include "cfgdn_defs.svh"
module cfgdn_mem_model (
  // Clock
  input wire logic clk,
  // From the loader
  input wire logic sel_n,
  input wire logic cmd,
  // Toward the loader and the bench
  output logic data,
  output logic cmd_seen
);
  logic [31:0] cmd_shift_r;
  logic streaming_r;
  logic [15:0] pat_r;

  initial begin
    cmd_shift_r = 32'h0000_0000;
    streaming_r = 1'b0;
    pat_r = 16'h0000;
    data = 1'b1;
    cmd_seen = 1'b0;
  end

  // Command shifts in MSB first; first data bit follows the edge that completes it
  // Deselected data line floats up through its pull-up
  always @(posedge clk) begin
    if (sel_n !== 1'b0) begin
      streaming_r <= 1'b0;
      pat_r <= 16'h0000;
      data <= 1'b1;
    end else begin
      cmd_shift_r <= {cmd_shift_r[30:0], cmd};
      if (streaming_r || {cmd_shift_r[30:0], cmd} == `CFGDN_READ_CMD) begin
        streaming_r <= 1'b1;
        cmd_seen <= 1'b1;
        data <= pat_r[0] ^ pat_r[3];
        pat_r <= pat_r + 16'h0001;
      end
    end
  end
endmodule : cfgdn_mem_model

// ===== verification/test_config_done_chain_handshake.sv
`timescale 1ns/100ps
`include "cfgdn_defs.svh"
module test_config_done_chain_handshake;
  // Bench-driven pins
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reconfig_request_n = 1'b1;
  logic chain_enable_in_n = 1'b1;
  logic strap = 1'b0;
  logic host_bit_valid = 1'b0;
  logic host_bit_data = 1'b0;
  logic load_error = 1'b0;
  logic usel = 1'b0;
  logic usel_oe = 1'b0;
  logic ucmd = 1'b0;
  logic ucmd_oe = 1'b0;
  logic ext_done_low = 1'b0;
  logic ext_status_low = 1'b0;
  // Design outputs
  logic chain_out_n, done_out, done_oe, status_out, status_oe;
  logic mem_data, sel_n, sel_oe, cmd, cmd_oe, cfg_valid, cfg_data, user_mode, cmd_seen;
  // Open-drain lines with pull-ups
  wire logic done_line = ~(done_oe & ~done_out) & ~ext_done_low;
  wire logic status_line = ~(status_oe & ~status_out) & ~ext_status_low;
  // Select and command float up through their pull-ups when not driven
  wire logic sel_line = sel_oe ? sel_n : 1'b1;
  wire logic cmd_line = cmd_oe ? cmd : 1'b1;
  int errors = 0;
  int check_count = 0;
  int rx_count = 0;
  int n;
  logic exp_q[$];

  always #12.5 clk = ~clk;

  cfgdn_loader uut (.clk(clk), .rst_b(rst_b), .reconfig_request_n(reconfig_request_n),
    .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_out_n),
    .config_complete_line_in(done_line), .config_complete_line_out(done_out),
    .config_complete_line_oe(done_oe), .error_status_line_n_in(status_line),
    .error_status_line_n_out(status_out), .error_status_line_n_oe(status_oe),
    .self_driven_serial_scheme(strap), .memory_data_in(mem_data),
    .memory_select_out_n(sel_n), .memory_select_oe(sel_oe), .serial_cmd_out(cmd),
    .serial_cmd_oe(cmd_oe), .host_bit_valid(host_bit_valid), .host_bit_data(host_bit_data),
    .load_error(load_error), .cfg_bit_valid(cfg_valid), .cfg_bit_data(cfg_data),
    .user_select_out(usel), .user_select_oe(usel_oe), .user_cmd_out(ucmd),
    .user_cmd_oe(ucmd_oe), .user_mode(user_mode));

  cfgdn_mem_model mem (.clk(clk), .sel_n(sel_line), .cmd(cmd_line), .data(mem_data),
    .cmd_seen(cmd_seen));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Memory pattern: streamed bit k is k[0] xor k[3]
  function automatic logic exp_mem_bit(input int k);
    return k[0] ^ k[3];
  endfunction : exp_mem_bit

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Reload request with the scheme strap settled well before release
  task automatic restart(input logic serial);
    strap <= serial;
    ext_done_low <= 1'b0;
    ext_status_low <= 1'b0;
    reconfig_request_n <= 1'b0;
    cyc(10);
    @(negedge clk);
    chk(user_mode, 1'b0, "user mode in reset");
    chk(done_oe, 1'b1, "done line driven in reset");
    chk(chain_out_n, 1'b1, "chain out before load");
    @(posedge clk);
    reconfig_request_n <= 1'b1;
    chain_enable_in_n <= 1'b0;
    cyc(14);
    rx_count = 0;
    exp_q.delete();
  endtask : restart

  // Random bits, mostly back to back with random gaps
  task automatic send(input int cnt, input bit take);
    int i;
    logic v;
    logic d;
    i = 0;
    while (i < cnt) begin
      @(posedge clk);
      v = ($urandom % 4) != 0;
      d = 1'($urandom);
      host_bit_valid <= v;
      host_bit_data <= d;
      if (v) begin
        i++;
        if (take) exp_q.push_back(d);
      end
    end
    @(posedge clk);
    host_bit_valid <= 1'b0;
  endtask : send

  // Array side: host bits must be ones that were sent, memory bits the known pattern
  always @(posedge clk) begin
    if (cfg_valid === 1'b1) begin
      rx_count++;
      if (strap === 1'b0) begin
        if (exp_q.size() == 0) chk(1, 0, "bit passed while refused");
        else chk(cfg_data, exp_q.pop_front(), "array bit");
      end else begin
        chk(cfg_data, exp_mem_bit(rx_count - 1), "serial bit");
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    void'($urandom(32'hD467));
    cyc(5);
    @(negedge clk);
    chk(done_oe, 1'b1, "done line driven under reset");
    @(posedge clk);
    rst_b <= 1'b1;
    // Host load, paused by chain enable, completion held low from outside
    restart(1'b0);
    send(16'h200, 1'b1);
    chain_enable_in_n <= 1'b1;
    cyc(8);
    send(20, 1'b0);
    chain_enable_in_n <= 1'b0;
    ext_done_low <= 1'b1;
    cyc(8);
    @(negedge clk);
    chk(sel_oe, 1'b0, "dual pin idle during load");
    send(16'h1FF, 1'b1);
    @(negedge clk);
    chk(done_oe, 1'b1, "done low before last bit");
    send(1, 1'b1);
    cyc(4);
    @(negedge clk);
    chk(done_oe, 1'b0, "done released after last bit");
    chk(rx_count, `CFGDN_CFG_BITS, "bits passed");
    cyc(120);
    @(negedge clk);
    chk(user_mode, 1'b0, "no init while line low");
    chk(chain_out_n, 1'b0, "next device enabled");
    @(posedge clk);
    ext_done_low <= 1'b0;
    n = 0;
    while (user_mode !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n >= `CFGDN_INIT_CYCLES && n <= `CFGDN_INIT_CYCLES + 12, 1, "init time");
    // User mode ignores both lines and hands the pins to user logic
    ext_done_low <= 1'b1;
    ext_status_low <= 1'b1;
    usel <= 1'($urandom);
    usel_oe <= 1'b1;
    ucmd <= 1'($urandom);
    ucmd_oe <= 1'($urandom);
    cyc(10);
    @(negedge clk);
    chk(user_mode, 1'b1, "user mode kept");
    chk(done_oe, 1'b0, "done stays released");
    chk(status_oe, 1'b0, "no error in user mode");
    chk(sel_n, usel, "select as user pin");
    chk(sel_oe, usel_oe, "select enable");
    chk(cmd, ucmd, "command as user pin");
    chk(cmd_oe, ucmd_oe, "command enable");
    $display("test host load done");
    // Errors: own load error, then an outside low on the status line
    restart(1'b0);
    send(16, 1'b1);
    load_error <= 1'b1;
    cyc(1);
    load_error <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(status_oe, 1'b1, "status low on load error");
    chk(done_oe, 1'b1, "done low in error");
    restart(1'b0);
    send(16, 1'b1);
    ext_status_low <= 1'b1;
    cyc(8);
    ext_status_low <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk(status_oe, 1'b1, "error on outside status low");
    chk(user_mode, 1'b0, "no user mode after error");
    $display("test errors done");
    // Serial memory scheme
    restart(1'b1);
    n = 0;
    while (rx_count < 16 && n < 200) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    chk(sel_n, 1'b0, "memory selected in load");
    chk(cmd_seen, 1'b1, "read command sent");
    n = 0;
    while (user_mode !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    chk(user_mode, 1'b1, "serial load completes");
    chk(rx_count, `CFGDN_CFG_BITS, "serial bits");
    chk(sel_n, 1'b1, "memory released");
    $display("test serial scheme done");
    end_sim();
  end
endmodule : test_config_done_chain_handshake
